// ### core/loop_ctrl_pkg.sv
package loop_ctrl_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [11:0] IDX_CLR_L0_LOCK   = 12'hA09;
    localparam logic [11:0] IDX_CLR_L0_STATE  = 12'hA0A;
    localparam logic [11:0] IDX_CLR_L0_ANALOG = 12'hA0B;
    localparam logic [11:0] IDX_CLR_L1_LOCK   = 12'hA0C;
    localparam logic [11:0] IDX_CLR_L1_STATE  = 12'hA0D;
    localparam logic [11:0] IDX_CLR_L1_ANALOG = 12'hA0E;
    localparam logic [11:0] IDX_SYNC_CAL      = 12'hA20;
    localparam logic [11:0] IDX_OUT_DISABLE   = 12'hA21;
    localparam logic [11:0] IDX_IRQ_MASK      = 12'hA30;
    localparam logic [11:0] IDX_IRQ_STATUS    = 12'hA31;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam logic [7:0] ANALOG_CLR_MASK  = 8'h1F;
    localparam int         SYNC_SOFT_BIT    = 2;
    localparam int         SYNC_CAL_BIT     = 1;
    localparam int         SYNC_PDOWN_BIT   = 0;
    localparam int         DIS_DRV_B_BIT    = 3;
    localparam int         DIS_DRV_A_BIT    = 2;
    localparam int         DIS_CHAN_B_BIT   = 1;
    localparam int         DIS_CHAN_A_BIT   = 0;
    localparam int         IRQ_CAL_BIT      = 0;
    localparam int         IRQ_RESTART_BIT  = 1;
    localparam int         IRQ_SLEEP_BIT    = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0] SYNC_CAL_RESET   = 3'h0;
    localparam logic [3:0] OUT_DIS_RESET    = 4'h0;
    localparam logic [2:0] IRQ_MASK_RESET   = 3'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] loop1Analog;
        logic [7:0] loop1State;
        logic [7:0] loop1Lock;
        logic [7:0] loop0Analog;
        logic [7:0] loop0State;
        logic [7:0] loop0Lock;
    } irq_clear_s;

    typedef struct packed {
        logic out0bDrvOff;
        logic out0aDrvOff;
        logic out0bDivOff;
        logic out0aDivOff;
    } out_ctrl_s;

    typedef struct packed {
        logic syncStall;
        logic syncRestart;
        logic calStart;
        logic pairSleep;
    } pair_ctrl_s;

endpackage

// ### core/loop_irq_clear_ctrl.sv
// Local design decision: the APB register port.
`timescale 1ns/10ps
// Functional notes
// [R1] Loop 0 lock clear bits 7..4 clear clamp exit/entry, slew exit/entry.
// [R2] Loop 0 lock clear bits 3..0 clear freq and phase lost/acquired.
// [R3] Loop 0 state clear bits 7..4: switching, free run, holdover, history.
// [R4] Loop 0 state clear bits 3..0: reference D, C, B, A activated.
// [R5] Analog loop 0 clear bits 4..0; bits 7..5 reserved.
// [R6] Loop 1 lock clear register uses the loop 0 layout.
// [R7] Loop 1 state clear register uses the loop 0 layout.
// [R8] Analog loop 1 clear bits 4..0; upper three bits reserved.
// [R9] Soft sync one stalls pair 0 outputs; one-to-zero restarts them.
// [R10] Calibration starts only when calibrate bit rises; zero does nothing.
// [R11] Calibrate bit holds written value; clear it before retriggering.
// [R12] Power-down bit sleeps loop 0, analog loop 0 and pair clock.
// [R13] Disable bit 3 powers down only output zero B driver.
// [R14] Disable bit 2 powers down only output zero A driver.
// [R15] With only driver off, the divider keeps running synchronized.
// [R16] Disable bit 1 powers down output zero B divider and driver.
// [R17] Disable bit 0 powers down output zero A divider and driver.
// [R18] Each clear bit written one pulses its monitor clear, then self-clears.
// [R19] Reserved bits read zero; writes to them are ignored.
module loop_irq_clear_ctrl
    import loop_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Monitor clear pulses
    output irq_clear_s       irqClear,
    // Channel pair 0 controls
    output pair_ctrl_s       pairCtrl,
    output out_ctrl_s        outCtrl,
    // Interrupt
    output logic             irq
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rstSync_q;
    logic       rstN;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end

    assign rstN = rstSync_q[1];

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic        aligned;
    logic [11:0] idx;
    logic        selL0Lock;
    logic        selL0State;
    logic        selL0Analog;
    logic        selL1Lock;
    logic        selL1State;
    logic        selL1Analog;
    logic        selSync;
    logic        selDis;
    logic        selMask;
    logic        selStatus;
    logic        selClr;
    logic        hit;

    assign aligned     = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0);
    assign idx         = paddr[13:2];
    assign selL0Lock   = aligned && (idx == IDX_CLR_L0_LOCK);
    assign selL0State  = aligned && (idx == IDX_CLR_L0_STATE);
    assign selL0Analog = aligned && (idx == IDX_CLR_L0_ANALOG);
    assign selL1Lock   = aligned && (idx == IDX_CLR_L1_LOCK);
    assign selL1State  = aligned && (idx == IDX_CLR_L1_STATE);
    assign selL1Analog = aligned && (idx == IDX_CLR_L1_ANALOG);
    assign selSync     = aligned && (idx == IDX_SYNC_CAL);
    assign selDis      = aligned && (idx == IDX_OUT_DISABLE);
    assign selMask     = aligned && (idx == IDX_IRQ_MASK);
    assign selStatus   = aligned && (idx == IDX_IRQ_STATUS);
    assign selClr      = selL0Lock | selL0State | selL0Analog
                       | selL1Lock | selL1State | selL1Analog;
    assign hit         = selClr | selSync | selDis | selMask | selStatus;

    // ------------------------------------------------------------
    // Bus phases: one wait state, then pready for one cycle
    // ------------------------------------------------------------
    logic accessWait;
    logic accessDone;
    logic wrDone;
    logic rdDone;
    logic pready_q;

    assign accessWait = psel && penable && !pready_q;
    assign accessDone = psel && penable && pready_q;
    assign wrDone     = accessDone && pwrite && hit;
    assign rdDone     = accessDone && !pwrite;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [2:0] syncCal_q;
    logic [2:0] syncCal_d;
    logic [3:0] disable_q;
    logic [3:0] disable_d;
    logic [2:0] mask_q;
    logic [2:0] mask_d;
    logic       wrSync;
    logic       wrDis;

    assign wrSync    = wrDone && selSync;
    assign wrDis     = wrDone && selDis;
    // Calibrate bit is stored as written, never self-cleared
    assign syncCal_d = wrSync ? pwdata[2:0] : syncCal_q; // [R11] [R19]
    assign disable_d = wrDis ? pwdata[3:0] : disable_q; // [R19]
    assign mask_d    = (wrDone && selMask) ? pwdata[2:0] : mask_q;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            syncCal_q <= SYNC_CAL_RESET;
            disable_q <= OUT_DIS_RESET;
            mask_q    <= IRQ_MASK_RESET;
        end else begin
            syncCal_q <= syncCal_d;
            disable_q <= disable_d;
            mask_q    <= mask_d;
        end
    end

    // ------------------------------------------------------------
    // Pair 0 sync, calibration and sleep
    // ------------------------------------------------------------
    logic       calStartD;
    logic       restartD;
    logic       sleepEntryD;
    pair_ctrl_s pairCtrl_d;
    pair_ctrl_s pairCtrl_q;

    assign calStartD   = wrSync && pwdata[SYNC_CAL_BIT]
                       && !syncCal_q[SYNC_CAL_BIT]; // [R10]
    assign restartD    = wrSync && !pwdata[SYNC_SOFT_BIT]
                       && syncCal_q[SYNC_SOFT_BIT]; // [R9]
    assign sleepEntryD = wrSync && pwdata[SYNC_PDOWN_BIT]
                       && !syncCal_q[SYNC_PDOWN_BIT];

    assign pairCtrl_d.syncStall   = syncCal_d[SYNC_SOFT_BIT]; // [R9]
    assign pairCtrl_d.syncRestart = restartD; // [R9]
    assign pairCtrl_d.calStart    = calStartD; // [R10]
    assign pairCtrl_d.pairSleep   = syncCal_d[SYNC_PDOWN_BIT]; // [R12]

    // ------------------------------------------------------------
    // Output drivers and dividers
    // ------------------------------------------------------------
    out_ctrl_s outCtrl_d;
    out_ctrl_s outCtrl_q;

    // Driver-only disable leaves the divider running and in sync
    assign outCtrl_d.out0bDrvOff = disable_d[DIS_DRV_B_BIT]
                                 | disable_d[DIS_CHAN_B_BIT]; // [R13] [R16]
    assign outCtrl_d.out0aDrvOff = disable_d[DIS_DRV_A_BIT]
                                 | disable_d[DIS_CHAN_A_BIT]; // [R14] [R17]
    assign outCtrl_d.out0bDivOff = disable_d[DIS_CHAN_B_BIT]; // [R15] [R16]
    assign outCtrl_d.out0aDivOff = disable_d[DIS_CHAN_A_BIT]; // [R15] [R17]

    // ------------------------------------------------------------
    // Monitor clear pulses
    // ------------------------------------------------------------
    irq_clear_s irqClear_d;
    irq_clear_s irqClear_q;
    logic [7:0] wrByte;

    assign wrByte                 = pwdata[7:0];
    assign irqClear_d.loop0Lock   = (wrDone && selL0Lock)
                                  ? wrByte : 8'h00; // [R1] [R2] [R18]
    assign irqClear_d.loop0State  = (wrDone && selL0State)
                                  ? wrByte : 8'h00; // [R3] [R4] [R18]
    assign irqClear_d.loop0Analog = (wrDone && selL0Analog)
                                  ? (wrByte & ANALOG_CLR_MASK)
                                  : 8'h00; // [R5] [R18]
    assign irqClear_d.loop1Lock   = (wrDone && selL1Lock)
                                  ? wrByte : 8'h00; // [R6] [R18]
    assign irqClear_d.loop1State  = (wrDone && selL1State)
                                  ? wrByte : 8'h00; // [R7] [R18]
    assign irqClear_d.loop1Analog = (wrDone && selL1Analog)
                                  ? (wrByte & ANALOG_CLR_MASK)
                                  : 8'h00; // [R8] [R18]

    // ------------------------------------------------------------
    // Interrupt status: set wins over read-clear
    // ------------------------------------------------------------
    logic [2:0]  status_q;
    logic [2:0]  status_d;
    logic [2:0]  statusSet;
    logic [2:0]  statusClr;
    logic [31:0] prdata_q;
    logic        irq_q;

    assign statusSet[IRQ_CAL_BIT]     = calStartD;
    assign statusSet[IRQ_RESTART_BIT] = restartD;
    assign statusSet[IRQ_SLEEP_BIT]   = sleepEntryD;
    // Only bits that were actually returned are cleared
    assign statusClr = (rdDone && selStatus) ? prdata_q[2:0] : 3'h0;
    assign status_d  = (status_q & ~statusClr) | statusSet;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] rdData;

    // Clear registers are write-only and read zero
    assign rdData = selSync   ? {29'h0, syncCal_q} :
                    selDis    ? {28'h0, disable_q} :
                    selMask   ? {29'h0, mask_q} :
                    selStatus ? {29'h0, status_q} :
                    32'h0; // [R19]

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pready_q   <= 1'b0;
            prdata_q   <= 32'h0;
            pslverr    <= 1'b0;
            status_q   <= 3'h0;
            irq_q      <= 1'b0;
            pairCtrl_q <= '0;
            outCtrl_q  <= '0;
            irqClear_q <= '0;
        end else begin
            pready_q   <= accessWait;
            prdata_q   <= (accessWait && !pwrite) ? rdData : 32'h0;
            pslverr    <= accessWait && !hit;
            status_q   <= status_d;
            irq_q      <= |(status_d & mask_q);
            pairCtrl_q <= pairCtrl_d;
            outCtrl_q  <= outCtrl_d;
            irqClear_q <= irqClear_d;
        end
    end

    assign pready   = pready_q;
    assign prdata   = prdata_q;
    assign irq      = irq_q;
    assign pairCtrl = pairCtrl_q;
    assign outCtrl  = outCtrl_q;
    assign irqClear = irqClear_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic wrL0Lock;
    logic wrL0State;
    logic wrL0Analog;
    logic wrL1Lock;
    logic wrL1State;
    logic wrL1Analog;
    logic wrAnyClr;

    assign wrL0Lock   = wrDone && selL0Lock;
    assign wrL0State  = wrDone && selL0State;
    assign wrL0Analog = wrDone && selL0Analog;
    assign wrL1Lock   = wrDone && selL1Lock;
    assign wrL1State  = wrDone && selL1State;
    assign wrL1Analog = wrDone && selL1Analog;
    assign wrAnyClr   = wrDone && selClr;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstN);

    lock0_upper_a: assert property ( // [R1]
        wrL0Lock |=> irqClear.loop0Lock[7:4] == $past(pwdata[7:4]))
        else $error("loop 0 clamp or slew clear mismatch");

    lock0_lower_a: assert property ( // [R2]
        wrL0Lock |=> irqClear.loop0Lock[3:0] == $past(pwdata[3:0]))
        else $error("loop 0 lock clear mismatch");

    state0_upper_a: assert property ( // [R3]
        wrL0State |=> irqClear.loop0State[7:4] == $past(pwdata[7:4]))
        else $error("loop 0 state clear mismatch");

    state0_refs_a: assert property ( // [R4]
        wrL0State |=> irqClear.loop0State[3:0] == $past(pwdata[3:0]))
        else $error("loop 0 reference clear mismatch");

    analog0_clear_a: assert property ( // [R5]
        wrL0Analog |=> irqClear.loop0Analog
                       == {3'h0, $past(pwdata[4:0])})
        else $error("analog loop 0 clear mismatch");

    lock1_clear_a: assert property ( // [R6]
        wrL1Lock |=> irqClear.loop1Lock == $past(pwdata[7:0]))
        else $error("loop 1 lock clear mismatch");

    state1_clear_a: assert property ( // [R7]
        wrL1State |=> irqClear.loop1State == $past(pwdata[7:0]))
        else $error("loop 1 state clear mismatch");

    analog1_clear_a: assert property ( // [R8]
        wrL1Analog |=> irqClear.loop1Analog
                       == {3'h0, $past(pwdata[4:0])})
        else $error("analog loop 1 clear mismatch");

    sync_restart_a: assert property ( // [R9]
        $fell(pairCtrl.syncStall) |-> pairCtrl.syncRestart
            ##1 !pairCtrl.syncRestart)
        else $error("stall release without one restart pulse");

    cal_edge_a: assert property ( // [R10]
        pairCtrl.calStart |-> $past(wrSync) && $past(pwdata[1])
            && !$past(syncCal_q[1]) && syncCal_q[1])
        else $error("calibration start without rising calibrate bit");

    cal_hold_a: assert property ( // [R11]
        !wrSync |=> $stable(syncCal_q[1]))
        else $error("calibrate bit changed without a write");

    sleep_follow_a: assert property ( // [R12]
        wrSync |=> pairCtrl.pairSleep == $past(pwdata[0]))
        else $error("pair sleep does not follow power-down bit");

    drv_b_only_a: assert property ( // [R13]
        disable_q[3] |-> outCtrl.out0bDrvOff)
        else $error("output zero B driver not off");

    drv_a_only_a: assert property ( // [R14]
        disable_q[2] |-> outCtrl.out0aDrvOff)
        else $error("output zero A driver not off");

    div_keeps_a: assert property ( // [R15]
        !disable_q[1] |-> !outCtrl.out0bDivOff
            && (outCtrl.out0aDivOff == disable_q[0]))
        else $error("divider stopped by driver-only disable");

    chan_b_off_a: assert property ( // [R16]
        disable_q[1] |-> outCtrl.out0bDivOff && outCtrl.out0bDrvOff)
        else $error("output zero B channel not fully off");

    chan_a_off_a: assert property ( // [R17]
        disable_q[0] |-> outCtrl.out0aDivOff && outCtrl.out0aDrvOff)
        else $error("output zero A channel not fully off");

    clear_pulse_a: assert property ( // [R18]
        !wrAnyClr |=> irqClear == '0)
        else $error("clear pulse without a clear write");

    reserved_zero_a: assert property ( // [R19]
        pready && !pwrite && (selClr || selSync || selDis)
            |-> prdata[31:4] == 28'h0 && (!selClr || prdata == 32'h0))
        else $error("reserved or write-only bits read nonzero");

    sync_store_a: assert property ( // [R19]
        wrSync |=> syncCal_q == $past(pwdata[2:0]))
        else $error("sync register does not keep written bits");

    cal_start_c: cover property (pairCtrl.calStart);
    drv_only_c: cover property (outCtrl.out0bDrvOff && !outCtrl.out0bDivOff);
    sync_cycle_c: cover property (pairCtrl.syncStall ##[1:50]
        pairCtrl.syncRestart);
    clear_lock_c: cover property (irqClear.loop0Lock != 8'h00);
    irq_raise_c: cover property ($rose(irq));

endmodule

// ### verif/testbench.sv
`timescale 1ns/10ps
module testbench;
    import loop_ctrl_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    irq_clear_s  irqClear;
    pair_ctrl_s  pairCtrl;
    out_ctrl_s   outCtrl;
    logic        irq;
    int          failCount;
    int          checked;
    logic [31:0] rdData;
    logic        rdErr;

    loop_irq_clear_ctrl loop_irq_clear_ctrl_i (
        .clk      (clk),
        .arst_n   (arst_n),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .irqClear (irqClear),
        .pairCtrl (pairCtrl),
        .outCtrl  (outCtrl),
        .irq      (irq)
    );

    always #12.5 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        if (failCount == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [47:0] seen, input logic [47:0] want);
        checked++;
        if (seen !== want) begin
            failCount++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    function automatic logic [15:0] addr(input logic [11:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction

    // One APB transfer; returns at the edge that completes it
    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            check(pready, 48'h1);
            complete_run();
        end else begin
            rdData = prdata;
            rdErr  = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic scn_reset();
        apb(1'b0, addr(IDX_SYNC_CAL), 32'h0);
        check({rdErr, rdData}, 48'h0);
        apb(1'b0, addr(IDX_OUT_DISABLE), 32'h0);
        check({rdErr, rdData}, 48'h0);
        check({pairCtrl, outCtrl, irq}, 48'h0);
    endtask

    task automatic scn_clear();
        logic [7:0]  pat [2];
        logic [7:0]  keep;
        logic [47:0] want;
        int          k;
        pat = '{8'hFF, 8'h96};
        for (int i = 0; i < 12; i++) begin
            k    = i / 2;
            keep = (k % 3 == 2) ? ANALOG_CLR_MASK : 8'hFF;
            want = 48'(pat[i % 2] & keep) << (8 * k);
            apb(1'b1, addr(12'(IDX_CLR_L0_LOCK + k)), {24'h0, pat[i % 2]});
            #1;
            check(irqClear, want);
            step();
            check(irqClear, 48'h0);
            apb(1'b0, addr(12'(IDX_CLR_L0_LOCK + k)), 32'h0);
            check(rdData, 48'h0);
        end
    endtask

    task automatic scn_irq();
        apb(1'b1, addr(IDX_SYNC_CAL), 32'h2);
        #1;
        check(pairCtrl, 48'h2);
        repeat (3) step();
        check(irq, 48'h0);
        apb(1'b1, addr(IDX_IRQ_MASK), 32'h7);
        repeat (3) step();
        check(irq, 48'h1);
        apb(1'b0, addr(IDX_IRQ_STATUS), 32'h0);
        check(rdData, 48'h1);
        repeat (3) step();
        check(irq, 48'h0);
        apb(1'b1, addr(IDX_SYNC_CAL), 32'h0);
    endtask

    task automatic scn_sync();
        apb(1'b1, addr(IDX_SYNC_CAL), 32'h2);
        #1;
        check(pairCtrl, 48'h2);
        apb(1'b1, addr(IDX_SYNC_CAL), 32'h2);
        #1;
        check(pairCtrl, 48'h0);
        apb(1'b0, addr(IDX_SYNC_CAL), 32'h0);
        check(rdData, 48'h2);
        apb(1'b1, addr(IDX_SYNC_CAL), 32'h0);
        #1;
        check(pairCtrl, 48'h0);
        apb(1'b1, addr(IDX_SYNC_CAL), 32'h4);
        #1;
        check(pairCtrl, 48'h8);
        step();
        check(pairCtrl, 48'h8);
        apb(1'b1, addr(IDX_SYNC_CAL), 32'h0);
        #1;
        check(pairCtrl, 48'h4);
        step();
        check(pairCtrl, 48'h0);
        apb(1'b1, addr(IDX_SYNC_CAL), 32'hF9);
        #1;
        check(pairCtrl, 48'h1);
        apb(1'b0, addr(IDX_SYNC_CAL), 32'h0);
        check(rdData, 48'h1);
        apb(1'b0, addr(IDX_IRQ_STATUS), 32'h0);
        check(rdData, 48'h7);
        apb(1'b1, addr(IDX_SYNC_CAL), 32'h0);
    endtask

    task automatic scn_out();
        logic [3:0] want [4];
        want = '{4'b1000, 4'b0100, 4'b1010, 4'b0101};
        for (int b = 0; b < 4; b++) begin
            apb(1'b1, addr(IDX_OUT_DISABLE), 32'hF0 | (32'h1 << (3 - b)));
            #1;
            check(outCtrl, want[b]);
            apb(1'b0, addr(IDX_OUT_DISABLE), 32'h0);
            check(rdData, 48'h1 << (3 - b));
        end
        apb(1'b1, addr(IDX_OUT_DISABLE), 32'h0);
        #1;
        check(outCtrl, 48'h0);
    endtask

    task automatic scn_midreset();
        apb(1'b1, addr(IDX_OUT_DISABLE), 32'hF);
        apb(1'b1, addr(IDX_SYNC_CAL), 32'h5);
        @(posedge clk);
        arst_n <= 1'b0;
        #1;
        check({pairCtrl, outCtrl, irq, pready}, 48'h0);
        @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, addr(IDX_SYNC_CAL), 32'h0);
        check({rdErr, rdData}, 48'h0);
        apb(1'b0, addr(IDX_OUT_DISABLE), 32'h0);
        check(rdData, 48'h0);
        apb(1'b0, addr(IDX_IRQ_STATUS), 32'h0);
        check({irq, rdData}, 48'h0);
    endtask

    task automatic scn_unmapped();
        apb(1'b1, addr(IDX_SYNC_CAL) | 16'h1, 32'h1);
        #1;
        check({rdErr, pairCtrl}, {1'b1, 4'h0});
        apb(1'b0, addr(IDX_SYNC_CAL) | 16'hC000, 32'h0);
        check({rdErr, rdData}, {1'b1, 32'h0});
        apb(1'b0, addr(12'hA0F), 32'h0);
        check({rdErr, rdData}, {1'b1, 32'h0});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clk       = 1'b0;
        arst_n    = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 16'h0;
        pwdata    = 32'h0;
        failCount = 0;
        checked   = 0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        scn_reset();
        scn_clear();
        scn_irq();
        scn_sync();
        scn_out();
        scn_midreset();
        scn_unmapped();
        complete_run();
    end
endmodule
